// file: spm_consts.svh
// Constants for the serial port and address pin mux
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
`define SPM_SEL_ADDR      16'h1C00
`define SPM_SP1_MSB       11
`define SPM_SP1_LSB       10
`define SPM_SP0_MSB       9
`define SPM_SP0_LSB       8
`define SPM_ADDR_MSB      5
`define SPM_ADDR_LSB      0
`define SPM_SP_RST        2'h0
`define SPM_ADDR_RST      6'h3F
`define SPM_BOOT_DELAY    4'hA
`define SPM_CNT_ONE       4'h1
`define SPM_PAD_OFF       12'h000
`define SPM_A17_BIT       2
`define SPM_RD_MASK       16'h0F3F
`endif

// file: spm_pkg.sv
// Types for the serial port and address pin mux
package spm_pkg;
   typedef struct packed {
      logic [5:0] out;
      logic [5:0] oe;
   } spm_pad_t;

   typedef enum logic [1:0] {
      SPM_MODE0 = 2'h0,
      SPM_MODE1 = 2'h1,
      SPM_MODE2 = 2'h2,
      SPM_MODE3 = 2'h3
   } spm_mode_t;

   typedef enum logic [0:0] {
      SPM_BOOT_WAIT = 1'h0,
      SPM_BOOT_DONE = 1'h1
   } spm_boot_t;
endpackage : spm_pkg

// file: spm_pin_mux.sv
// Serial port 0/1 and upper address pin mux with selection register
//
// Behaviour
// - Port1 code 00 routes card interface one
// - Port1 code 01 routes multichannel serial peripheral
// - Port1 code 10 routes general lines 11:6
// - Port0 code 00 routes card interface zero
// - Port0 code 01 routes audio plus lines 5:4
// - Port0 code 10 routes general lines 5:0
// - Port0 code 11 routes buffered serial peripheral
// - Bits 7:6 read zero, writes ignored
// - Bit 5 picks address 20 or line 26
// - Bit 4 picks address 19 or line 25
// - Bit 3 picks address 18 or line 24
// - Reset selects general lines on address pins, card interfaces on serial ports, pins input
// - Pin levels latched ten cycles after reset
// - addr_line17_pin_sel is select bit 2, address 17 or line 23
// - Bit 2 picks address 17 or line 23
// - Bits 1,0 pick address 16/15 or lines
// - New routing reaches the pins two clock cycles after the write
`timescale 1ns/1ps
`include "spm_consts.svh"

module spm_pin_mux
   import spm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // CPU register port
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   output      logic [15:0] reg_rdata,
   // Peripheral drive
   input  wire spm_pad_t    card_interface_one_o,
   input  wire spm_pad_t    multichannel_serial_periph_o,
   input  wire spm_pad_t    general_purpose_line_11_6_o,
   input  wire spm_pad_t    card_interface_zero_o,
   input  wire spm_pad_t    audio_serial_zero_o,
   input  wire spm_pad_t    buffered_serial_periph_o,
   input  wire spm_pad_t    general_purpose_line_5_0_o,
   input  wire spm_pad_t    general_purpose_line_26_21_o,
   input  wire logic [5:0]  ext_mem_address_bus_20_15,
   // Peripheral receive
   output      logic [5:0]  card_interface_one_i,
   output      logic [5:0]  multichannel_serial_periph_i,
   output      logic [5:0]  general_purpose_line_11_6_i,
   output      logic [5:0]  card_interface_zero_i,
   output      logic [5:0]  audio_serial_zero_i,
   output      logic [5:0]  buffered_serial_periph_i,
   output      logic [5:0]  general_purpose_line_5_0_i,
   output      logic [5:0]  general_purpose_line_26_21_i,
   // Boot mode capture
   output      logic [5:0]  boot_mode,
   output      logic        boot_mode_valid,
   // Package pins
   input  wire logic [5:0]  sp1_pin_in,
   output      logic [5:0]  sp1_pin_out,
   output      logic [5:0]  sp1_pin_oe,
   input  wire logic [5:0]  sp0_pin_in,
   output      logic [5:0]  sp0_pin_out,
   output      logic [5:0]  sp0_pin_oe,
   input  wire logic [5:0]  addr_pin_in,
   output      logic [5:0]  addr_pin_out,
   output      logic [5:0]  addr_pin_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // Selection register
   spm_mode_t  serial_port1_route_sel_ff;
   spm_mode_t  serial_port0_route_sel_ff;
   logic [5:0] addr_pin_sel_ff;
   logic [15:0] reg_rdata_ff;
   logic       sel_wr;
   logic       addr_line17_pin_sel;

   assign sel_wr = reg_wr && (reg_addr == `SPM_SEL_ADDR);
   assign addr_line17_pin_sel = addr_pin_sel_ff[`SPM_A17_BIT];

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         serial_port1_route_sel_ff <= spm_mode_t'(`SPM_SP_RST);
         serial_port0_route_sel_ff <= spm_mode_t'(`SPM_SP_RST);
         addr_pin_sel_ff           <= `SPM_ADDR_RST;
      end
      else if (sel_wr)
      begin
         serial_port1_route_sel_ff <= spm_mode_t'(reg_wdata[`SPM_SP1_MSB:`SPM_SP1_LSB]);
         serial_port0_route_sel_ff <= spm_mode_t'(reg_wdata[`SPM_SP0_MSB:`SPM_SP0_LSB]);
         addr_pin_sel_ff           <= reg_wdata[`SPM_ADDR_MSB:`SPM_ADDR_LSB];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         reg_rdata_ff <= 16'h0000;
      else
         reg_rdata_ff <= {4'h0, serial_port1_route_sel_ff, serial_port0_route_sel_ff,
                          2'h0, addr_pin_sel_ff};
   end

   assign reg_rdata = reg_rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers
   logic [17:0] pin_meta_ff;
   logic [17:0] pin_sync_ff;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pin_meta_ff <= 18'h00000;
         pin_sync_ff <= 18'h00000;
      end
      else
      begin
         pin_meta_ff <= {addr_pin_in, sp0_pin_in, sp1_pin_in};
         pin_sync_ff <= pin_meta_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Routing
   function automatic spm_pad_t route6(spm_mode_t sel, spm_pad_t m0, spm_pad_t m1,
                                        spm_pad_t m2, spm_pad_t m3, logic m3_ok);
      spm_pad_t r;
      r = `SPM_PAD_OFF;
      case (sel)
         SPM_MODE0: r = m0;
         SPM_MODE1: r = m1;
         SPM_MODE2: r = m2;
         SPM_MODE3: r = m3_ok ? m3 : spm_pad_t'(`SPM_PAD_OFF);
         default:   r = `SPM_PAD_OFF;
      endcase
      return r;
   endfunction : route6
   spm_pad_t   sp1_pad_ff;
   spm_pad_t   sp0_pad_ff;
   spm_pad_t   audio_mix;
   logic [5:0] addr_out_ff;
   logic [5:0] addr_oe_ff;

   assign audio_mix.out = {general_purpose_line_5_0_o.out[5:4], audio_serial_zero_o.out[3:0]};
   assign audio_mix.oe  = {general_purpose_line_5_0_o.oe[5:4], audio_serial_zero_o.oe[3:0]};

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         sp1_pad_ff <= `SPM_PAD_OFF;
         sp0_pad_ff <= `SPM_PAD_OFF;
      end
      else
      begin
         sp1_pad_ff <= route6(serial_port1_route_sel_ff, card_interface_one_o,
                              multichannel_serial_periph_o, general_purpose_line_11_6_o,
                              spm_pad_t'(`SPM_PAD_OFF), 1'b0);
         sp0_pad_ff <= route6(serial_port0_route_sel_ff, card_interface_zero_o, audio_mix,
                              general_purpose_line_5_0_o, buffered_serial_periph_o,
                              1'b1);
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++)
      begin : g_addr
         always_ff @(posedge clk)
         begin
            if (!resetn)
            begin
               addr_out_ff[gi] <= 1'b0;
               addr_oe_ff[gi]  <= 1'b0;
            end
            else if (addr_pin_sel_ff[gi])
            begin
               addr_out_ff[gi] <= general_purpose_line_26_21_o.out[gi];
               addr_oe_ff[gi]  <= general_purpose_line_26_21_o.oe[gi];
            end
            else
            begin
               addr_out_ff[gi] <= ext_mem_address_bus_20_15[gi];
               addr_oe_ff[gi]  <= 1'b1;
            end
         end
      end
   endgenerate

   assign sp1_pin_out  = sp1_pad_ff.out;
   assign sp1_pin_oe   = sp1_pad_ff.oe;
   assign sp0_pin_out  = sp0_pad_ff.out;
   assign sp0_pin_oe   = sp0_pad_ff.oe;
   assign addr_pin_out = addr_out_ff;
   assign addr_pin_oe  = addr_oe_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Receive side
   logic [5:0] rx_ff [8];

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         for (int k = 0; k < 8; k++)
            rx_ff[k] <= 6'h00;
      end
      else
      begin
         rx_ff[0] <= (serial_port1_route_sel_ff == SPM_MODE0) ? pin_sync_ff[5:0] : 6'h00;
         rx_ff[1] <= (serial_port1_route_sel_ff == SPM_MODE1) ? pin_sync_ff[5:0] : 6'h00;
         rx_ff[2] <= (serial_port1_route_sel_ff == SPM_MODE2) ? pin_sync_ff[5:0] : 6'h00;
         rx_ff[3] <= (serial_port0_route_sel_ff == SPM_MODE0) ? pin_sync_ff[11:6] : 6'h00;
         rx_ff[4] <= (serial_port0_route_sel_ff == SPM_MODE1) ?
                     {2'h0, pin_sync_ff[9:6]} : 6'h00;
         rx_ff[5] <= (serial_port0_route_sel_ff == SPM_MODE3) ? pin_sync_ff[11:6] : 6'h00;
         rx_ff[6] <= (serial_port0_route_sel_ff == SPM_MODE2) ? pin_sync_ff[11:6] :
                     (serial_port0_route_sel_ff == SPM_MODE1) ?
                     {pin_sync_ff[11:10], 4'h0} : 6'h00;
         rx_ff[7] <= pin_sync_ff[17:12] & addr_pin_sel_ff;
      end
   end

   assign card_interface_one_i         = rx_ff[0];
   assign multichannel_serial_periph_i = rx_ff[1];
   assign general_purpose_line_11_6_i  = rx_ff[2];
   assign card_interface_zero_i        = rx_ff[3];
   assign audio_serial_zero_i          = rx_ff[4];
   assign buffered_serial_periph_i     = rx_ff[5];
   assign general_purpose_line_5_0_i   = rx_ff[6];
   assign general_purpose_line_26_21_i = rx_ff[7];

   ////////////////////////////////////////////////////////////////////////////////
   // Boot mode capture
   spm_boot_t  boot_state_ff;
   logic [3:0] boot_cnt_ff;
   logic [5:0] boot_mode_ff;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         boot_state_ff <= SPM_BOOT_WAIT;
         boot_cnt_ff   <= 4'h0;
         boot_mode_ff  <= 6'h00;
      end
      else
      begin
         case (boot_state_ff)
            SPM_BOOT_WAIT:
            begin
               boot_cnt_ff <= boot_cnt_ff + `SPM_CNT_ONE;
               if (boot_cnt_ff == `SPM_BOOT_DELAY - `SPM_CNT_ONE)
               begin
                  boot_mode_ff  <= pin_sync_ff[17:12];
                  boot_state_ff <= SPM_BOOT_DONE;
               end
            end
            SPM_BOOT_DONE: boot_state_ff <= SPM_BOOT_DONE;
            default:       boot_state_ff <= SPM_BOOT_WAIT;
         endcase
      end
   end

   assign boot_mode       = boot_mode_ff;
   assign boot_mode_valid = (boot_state_ff == SPM_BOOT_DONE);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sp1_card_route_a: assert property (@(posedge clk) disable iff (!resetn)
      $past(serial_port1_route_sel_ff) == SPM_MODE0 && $past(resetn)
      |-> sp1_pad_ff == $past(card_interface_one_o)) else $error("sp1 card route");
   sp1_spi_route_a: assert property (@(posedge clk) disable iff (!resetn)
      $past(serial_port1_route_sel_ff) == SPM_MODE1 && $past(resetn)
      |-> sp1_pad_ff == $past(multichannel_serial_periph_o)) else $error("sp1 spi route");
   sp1_rsvd_off_a: assert property (@(posedge clk) disable iff (!resetn)
      serial_port1_route_sel_ff == SPM_MODE3 |=> sp1_pin_oe == 6'h00) else $error("sp1 rsvd");
   sp0_bsp_route_a: assert property (@(posedge clk) disable iff (!resetn)
      serial_port0_route_sel_ff == SPM_MODE3 ##1 resetn
      |-> sp0_pad_ff == $past(buffered_serial_periph_o)) else $error("sp0 bsp route");
   sp0_audio_mix_a: assert property (@(posedge clk) disable iff (!resetn)
      serial_port0_route_sel_ff == SPM_MODE1 |=>
      sp0_pin_out[5:4] == $past(general_purpose_line_5_0_o.out[5:4])) else $error("sp0 mix");
   rsvd_bits_zero_a: assert property (@(posedge clk) disable iff (!resetn)
      sel_wr |-> ##2 reg_rdata == ($past(reg_wdata, 2) & `SPM_RD_MASK)) else $error("readback");
   addr_external_memory_port_drive_a: assert property (@(posedge clk) disable iff (!resetn)
      sel_wr && !reg_wdata[0] |=> ##1 addr_pin_oe[0]) else $error("addr15 not driven");
   boot_latch_a: assert property (@(posedge clk)
      !resetn ##1 resetn [*8] ##1 resetn ##1 resetn |-> !boot_mode_valid ##1
      (boot_mode_valid || !resetn)) else $error("boot latch timing");
   reset_gp_a: assert property (@(posedge clk)
      !resetn |=> addr_pin_sel_ff == `SPM_ADDR_RST && addr_pin_oe == 6'h00) else $error("reset mode");
   addr17_route_a: assert property (@(posedge clk) disable iff (!resetn)
      !addr_line17_pin_sel |=> addr_pin_oe[`SPM_A17_BIT] && addr_pin_out[`SPM_A17_BIT] ==
      $past(ext_mem_address_bus_20_15[`SPM_A17_BIT])) else $error("addr17 route");

endmodule : spm_pin_mux

// file: spm_board.sv
// Board model driving the shared serial and address pins
`timescale 1ns/1ps

module spm_board
(
   // Device pin drive
   input  wire logic [17:0] dev_out,
   input  wire logic [17:0] dev_oe,
   // Board strap levels
   input  wire logic [17:0] strap,
   // Resolved pin levels
   output      logic [17:0] pin_lvl
);
   // Device wins where it drives, board strap elsewhere
   assign pin_lvl = (dev_oe & dev_out) | (~dev_oe & strap);
endmodule : spm_board

// file: testbench.sv
// Testbench for the serial port and address pin mux
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end

module testbench
   import spm_pkg::*;
;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        reg_wr = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [15:0] reg_wdata = 16'h0000;
   wire  [15:0] reg_rdata;
   spm_pad_t    c1o, mso, g11o, c0o, auo, bso, g50o, g26o;
   logic [5:0]  ema;
   wire  [5:0]  c1i, msi, g11i, c0i, aui, bsi, g50i, g26i, bm;
   wire         bmv;
   wire  [5:0]  s1o, s1e, s0o, s0e, apo, ape;
   wire  [17:0] lvl;
   logic [17:0] strap = 18'h00000;
   logic [127:0] rnd;
   integer      seed = 32'hBC9E;
   int          n_fail = 0;
   int          checked = 0;
   int          cyc = 0;

   always #2.5 clk = ~clk;

   spm_pin_mux DUT (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .card_interface_one_o(c1o),
      .multichannel_serial_periph_o(mso), .general_purpose_line_11_6_o(g11o),
      .card_interface_zero_o(c0o), .audio_serial_zero_o(auo), .buffered_serial_periph_o(bso),
      .general_purpose_line_5_0_o(g50o), .general_purpose_line_26_21_o(g26o),
      .ext_mem_address_bus_20_15(ema), .card_interface_one_i(c1i),
      .multichannel_serial_periph_i(msi), .general_purpose_line_11_6_i(g11i),
      .card_interface_zero_i(c0i), .audio_serial_zero_i(aui), .buffered_serial_periph_i(bsi),
      .general_purpose_line_5_0_i(g50i), .general_purpose_line_26_21_i(g26i),
      .boot_mode(bm), .boot_mode_valid(bmv), .sp1_pin_in(lvl[17:12]), .sp1_pin_out(s1o),
      .sp1_pin_oe(s1e), .sp0_pin_in(lvl[11:6]), .sp0_pin_out(s0o), .sp0_pin_oe(s0e),
      .addr_pin_in(lvl[5:0]), .addr_pin_out(apo), .addr_pin_oe(ape));

   spm_board BRD (.dev_out({s1o, s0o, apo}), .dev_oe({s1e, s0e, ape}), .strap(strap),
      .pin_lvl(lvl));

   ////////////////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
   endtask : wr

   task automatic shake;
      rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      {c1o, mso, g11o, c0o, auo, bso, g50o, g26o, ema} = rnd[101:0];
      strap = rnd[119:102];
   endtask : shake

   function automatic spm_pad_t e_sp1(input logic [1:0] m);
      case (m)
         2'h0: return c1o;
         2'h1: return mso;
         2'h2: return g11o;
         default: return '0;
      endcase
   endfunction : e_sp1

   function automatic spm_pad_t e_sp0(input logic [1:0] m);
      case (m)
         2'h0: return c0o;
         2'h1: return '{out: {g50o.out[5:4], auo.out[3:0]}, oe: {g50o.oe[5:4], auo.oe[3:0]}};
         2'h2: return g50o;
         default: return bso;
      endcase
   endfunction : e_sp0

   function automatic spm_pad_t e_ad(input logic [5:0] s);
      return '{out: (s & g26o.out) | (~s & ema), oe: (s & g26o.oe) | ~s};
   endfunction : e_ad

   function automatic logic [17:0] e_rx(input logic [1:0] m, input logic [5:0] w);
      return {(m == 2'h0) ? w : 6'h00, (m == 2'h1) ? w : 6'h00, (m == 2'h2) ? w : 6'h00};
   endfunction : e_rx

   function automatic logic [17:0] e_rx0(input logic [1:0] m, input logic [5:0] w);
      return {(m == 2'h1) ? {2'h0, w[3:0]} : 6'h00, (m == 2'h3) ? w : 6'h00,
              (m == 2'h2) ? w : (m == 2'h1) ? {w[5:4], 4'h0} : 6'h00};
   endfunction : e_rx0

   ////////////////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_fail++;
         report_and_stop;
      end
   end

   initial
   begin
      logic [15:0] d;
      logic [5:0]  bmx;
      shake;
      g26o.oe = 6'h00;
      bmx = strap[5:0];
      tick(5);
      `CHK({s1e, s0e, ape}, 18'h00000)
      tick(3);
      resetn = 1'b1;
      tick(2);
      `CHK(reg_rdata, 16'h003F)
      `CHK(ape, 6'h00)
      tick(7);
      `CHK(bmv, 1'b0)
      tick(3);
      `CHK(bm, bmx)
      `CHK(bmv, 1'b1)
      $display("Test reset and boot done");
      for (int i = 0; i < 24; i++)
      begin
         shake;
         d = rnd[127:112];
         if (i < 16)
            d[11:8] = i[3:0];
         wr(16'h1C00, d);
         tick(2);
         `CHK(reg_rdata, d & 16'h0F3F)
         `CHK({s1o, s1e}, e_sp1(d[11:10]))
         `CHK({s0o, s0e}, e_sp0(d[9:8]))
         `CHK({apo, ape}, e_ad(d[5:0]))
         tick(4);
         `CHK({c1i, msi, g11i}, e_rx(d[11:10], lvl[17:12]))
         `CHK(c0i, (d[9:8] == 2'h0) ? lvl[11:6] : 6'h00)
         `CHK({aui, bsi, g50i}, e_rx0(d[9:8], lvl[11:6]))
         `CHK(g26i, lvl[5:0] & d[5:0])
      end
      $display("Test routing done");
      wr(16'h1C01, ~d);
      tick(2);
      `CHK(reg_rdata, d & 16'h0F3F)
      `CHK({s1o, s1e}, e_sp1(d[11:10]))
      `CHK(bm, bmx)
      $display("Test unmapped write done");
      g26o.oe = 6'h00;
      bmx = strap[5:0];
      resetn = 1'b0;
      tick(2);
      `CHK({s1e, s0e, ape}, 18'h00000)
      `CHK(bmv, 1'b0)
      resetn = 1'b1;
      tick(9);
      `CHK(reg_rdata, 16'h003F)
      `CHK(bmv, 1'b0)
      tick(2);
      `CHK(bm, bmx)
      `CHK(bmv, 1'b1)
      $display("Test mid-run reset done");
      report_and_stop;
   end
endmodule : testbench
